// File: adcsr_analog_model.sv
/*
  Analog input source facing the converter.
  Assumes a held input level expressed in reference/256 steps.
*/
`timescale 1ns/100ps
// ==========================================================
// Analog source
module adcsr_analog_model (
  // Trial value and held level
  input wire logic [7:0] dac_in,
  input wire logic [7:0] level_in,
  // Comparator decision
  output logic comp_out
);
  // Level at or above the trial reads one, so one step gives code one
  assign comp_out = (level_in >= dac_in);
endmodule

// File: adcsr_ctrl.sv
/*
  Converter control: register file, successive-approximation sequencer,
  sleep and reset behaviour, and the converter interrupt.
  Assumes the core provides a one-cycle register port, a sleep level, a
  power-on indication and a comparator result from the analog front end.
*/
`timescale 1ns/100ps

// How it works
// - Only the RC clock code lets a conversion continue while sleeping.
// - With RC clock, conversion start waits one instruction cycle.
// - Completion clears the start bit and loads the result register.
// - Done during sleep with its interrupt enabled wakes the device.
// - Done during sleep without interrupt powers converter down, on bit stays.
// - Non-RC clock: sleep aborts conversion, powers down, on bit stays.
// - Any reset restores registers, powers down, aborts conversion.
// - Result survives non power-on resets; undefined after power-on.
// - Code steps from zero at one step, reference split in 256.
// - Interrupt control answers at both bank addresses.
// - Unimplemented register bits read as zero.
module adcsr_ctrl #(
  parameter int TAD_CYC = adcsr_pkg::TAD_CYC_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Core state
  input wire logic sleep_in,
  output logic wake_out,
  // Analog front end
  input wire logic comp_in,
  output logic [7:0] dac_out,
  output logic [1:0] channel_out,
  output logic powered_out,
  output logic sample_out,
  // Interrupt
  output logic irq_out
);
  typedef enum logic [1:0] {
    ADCSR_IDLE = 2'b00,
    ADCSR_DELAY = 2'b01,
    ADCSR_CONV = 2'b10
  } adcsr_state_t;

  // ==========================================================
  // Timing notes for the sequencer
  //
  // A trial value leaves sar_ff on one edge and reaches dac_out on the
  // next. The analog source then answers through comp_in at once, but
  // that answer is asynchronous to us. It passes three flip-flops and
  // the agreement filter before comp_ff may be trusted.
  //
  // Counting from the edge that loads a new trial:
  //   +1  dac_out shows the trial
  //   +2  first synchroniser stage holds the answer
  //   +3  second stage holds it
  //   +4  third stage holds it
  //   +5  comp_ff takes it, since stages two and three agree
  //   +6  earliest edge that may decide on the trial
  //
  // Every bit period is therefore stretched by SETTLE_CYC clocks on top
  // of TAD_CYC. Deciding any sooner would judge the trial by the answer
  // to the previous one, and the result would walk away from the input.
  // The cost is a slower conversion; the benefit is that the filter can
  // reject a single-clock glitch on the comparator.
  //
  // The same stretch applies to the first trial. Before the start the
  // comparator still answers for whatever dac_out held last, so the
  // first decision must also wait for the new answer.
  //
  // With the RC clock the sequencer first spends one instruction cycle
  // in the delay state. This gives the core time to enter sleep before
  // the first decision, so the digital switching noise is quiet during the
  // conversion.
  //
  // An abort may come in any state but idle. It clears the start bit and
  // returns to idle without touching the result or the done flag.
  // Clearing the on bit also returns to idle, but leaves the start bit set.
  //
  // The wait counter is four bits wide. TAD_CYC - 1 + SETTLE_CYC must
  // stay below sixteen, which limits TAD_CYC to twelve.
  localparam int SETTLE_CYC = 4;

  // ==========================================================
  // Comparator input synchroniser
  logic [2:0] comp_sync_ff;
  logic comp_ff;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      comp_sync_ff <= 3'h0;
    end else begin
      comp_sync_ff <= {comp_sync_ff[1:0], comp_in};
    end
  end
  // Accept a level once the last two stages agree
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      comp_ff <= 1'b0;
    end else if (comp_sync_ff[2] == comp_sync_ff[1]) begin
      comp_ff <= comp_sync_ff[2];
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] ctl_ff;
  logic [7:0] irqctl_ff;
  logic done_flag_ff;
  logic done_en_ff;
  logic [2:0] pincfg_ff;
  logic [7:0] result_ff;
  logic [7:0] irq_mask_ff;
  logic powered_ff;
  adcsr_state_t state_ff;
  logic [3:0] wait_ff;
  logic [3:0] bit_ff;
  logic [7:0] sar_ff;
  logic done_evt;
  logic abort_evt;
  logic start_evt;
  logic rc_clk;
  logic irq_ctl_hit;

  assign rc_clk = (ctl_ff[adcsr_pkg::CTL_CLK_HI:adcsr_pkg::CTL_CLK_LO] == adcsr_pkg::CLK_SEL_RC);
  assign irq_ctl_hit = (addr_in == adcsr_pkg::ADDR_IRQ_CONTROL) || (addr_in == adcsr_pkg::ADDR_IRQ_CONTROL_HI);
  // Start only while the module is on
  assign start_evt = wr_in && (addr_in == adcsr_pkg::ADDR_CONV_CONTROL) && wdata_in[adcsr_pkg::CTL_GO_BIT]
                     && wdata_in[adcsr_pkg::CTL_ON_BIT] && (state_ff == ADCSR_IDLE);
  // Sleep with a non-RC clock kills a running conversion
  assign abort_evt = sleep_in && !rc_clk && (state_ff != ADCSR_IDLE);
  assign done_evt = (state_ff == ADCSR_CONV) && (bit_ff == adcsr_pkg::CNT_ZERO)
                    && (wait_ff == adcsr_pkg::CNT_ZERO) && !abort_evt;

  // Control register; hardware clear of the start bit wins over writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_ff <= adcsr_pkg::RST_ZERO;
    end else begin
      if (wr_in && addr_in == adcsr_pkg::ADDR_CONV_CONTROL) begin
        ctl_ff <= wdata_in & adcsr_pkg::CTL_WRITE_MASK;
        if (!start_evt && state_ff == ADCSR_IDLE) begin
          ctl_ff[adcsr_pkg::CTL_GO_BIT] <= 1'b0;
        end else if (state_ff != ADCSR_IDLE) begin
          ctl_ff[adcsr_pkg::CTL_GO_BIT] <= 1'b1;
        end
      end
      if (done_evt || abort_evt) begin
        ctl_ff[adcsr_pkg::CTL_GO_BIT] <= 1'b0;
      end
    end
  end

  // Interrupt control, enable, pin configuration, interrupt mask
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irqctl_ff <= adcsr_pkg::RST_ZERO;
      done_en_ff <= 1'b0;
      pincfg_ff <= 3'h0;
      irq_mask_ff <= adcsr_pkg::RST_ZERO;
    end else if (wr_in) begin
      if (irq_ctl_hit) begin
        irqctl_ff <= wdata_in;
      end
      if (addr_in == adcsr_pkg::ADDR_PERIPH_ENABLE) begin
        done_en_ff <= wdata_in[adcsr_pkg::DONE_BIT];
      end
      if (addr_in == adcsr_pkg::ADDR_PIN_CONFIG) begin
        pincfg_ff <= wdata_in[2:0];
      end
      if (addr_in == adcsr_pkg::ADDR_IRQ_MASK) begin
        irq_mask_ff <= wdata_in & adcsr_pkg::DONE_MASK;
      end
    end
  end

  // Sticky done flag: write one to clear, a new event wins the race
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_flag_ff <= 1'b0;
    end else if (done_evt) begin
      done_flag_ff <= 1'b1;
    end else if (wr_in && addr_in == adcsr_pkg::ADDR_PERIPH_FLAG && wdata_in[adcsr_pkg::DONE_BIT]) begin
      done_flag_ff <= 1'b0;
    end
  end

  // Result is kept across ordinary resets; power-on clears it as a
  // defined stand-in for the undefined content
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      result_ff <= adcsr_pkg::RST_ZERO;
    end else if (done_evt) begin
      result_ff <= sar_ff;
    end
  end

  // ==========================================================
  // Sequencer: RC start delay, then one bit per conversion period
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ADCSR_IDLE;
      wait_ff <= adcsr_pkg::CNT_ZERO;
      bit_ff <= adcsr_pkg::CNT_ZERO;
      sar_ff <= adcsr_pkg::RST_ZERO;
    end else begin
      unique case (state_ff)
        ADCSR_IDLE: begin
          if (start_evt) begin
            sar_ff <= 8'h80;
            bit_ff <= 4'(adcsr_pkg::RES_BITS);
            if (wdata_in[adcsr_pkg::CTL_CLK_HI:adcsr_pkg::CTL_CLK_LO] == adcsr_pkg::CLK_SEL_RC) begin
              state_ff <= ADCSR_DELAY;
              wait_ff <= 4'(adcsr_pkg::INSTR_CYC - 1);
            end else begin
              state_ff <= ADCSR_CONV;
              wait_ff <= 4'(TAD_CYC - 1 + SETTLE_CYC);
            end
          end
        end
        ADCSR_DELAY: begin
          if (abort_evt || !ctl_ff[adcsr_pkg::CTL_ON_BIT]) begin
            state_ff <= ADCSR_IDLE;
          end else if (wait_ff == adcsr_pkg::CNT_ZERO) begin
            state_ff <= ADCSR_CONV;
            wait_ff <= 4'(TAD_CYC - 1 + SETTLE_CYC);
          end else begin
            wait_ff <= wait_ff - adcsr_pkg::CNT_ONE;
          end
        end
        ADCSR_CONV: begin
          if (abort_evt || !ctl_ff[adcsr_pkg::CTL_ON_BIT]) begin
            state_ff <= ADCSR_IDLE;
          end else if (wait_ff != adcsr_pkg::CNT_ZERO) begin
            wait_ff <= wait_ff - adcsr_pkg::CNT_ONE;
          end else if (bit_ff == adcsr_pkg::CNT_ZERO) begin
            state_ff <= ADCSR_IDLE;
          end else begin
            // Comparator high: input at or above trial, keep the bit;
            // first code step lands at reference / 256
            wait_ff <= 4'(TAD_CYC - 1 + SETTLE_CYC);
            bit_ff <= bit_ff - adcsr_pkg::CNT_ONE;
            if (!comp_ff) begin
              sar_ff[3'(bit_ff - adcsr_pkg::CNT_ONE)] <= 1'b0;
            end
            if (bit_ff != adcsr_pkg::CNT_ONE) begin
              sar_ff[3'(bit_ff - 4'h2)] <= 1'b1;
            end
          end
        end
        default: begin
          state_ff <= ADCSR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Power state: on bit powers up while awake; sleep with a non-RC clock,
  // or completion in sleep without its interrupt, powers down while the on
  // bit stays set, since only the analog part is switched off
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      powered_ff <= 1'b0;
    end else if (!ctl_ff[adcsr_pkg::CTL_ON_BIT]) begin
      powered_ff <= 1'b0;
    end else if (sleep_in && !rc_clk) begin
      powered_ff <= 1'b0;
    end else if (sleep_in && done_evt && !done_en_ff) begin
      powered_ff <= 1'b0;
    end else if (!sleep_in) begin
      powered_ff <= 1'b1;
    end
  end

  // Wake pulse on completion in sleep with the converter interrupt on
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= sleep_in && done_evt && done_en_ff;
    end
  end

  // ==========================================================
  // Read data one cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= adcsr_pkg::RST_ZERO;
    end else if (rd_in) begin
      if (irq_ctl_hit) begin
        rdata_out <= irqctl_ff;
      end else if (addr_in == adcsr_pkg::ADDR_PERIPH_FLAG) begin
        rdata_out <= {1'b0, done_flag_ff, 6'h00};
      end else if (addr_in == adcsr_pkg::ADDR_PERIPH_ENABLE) begin
        rdata_out <= {1'b0, done_en_ff, 6'h00};
      end else if (addr_in == adcsr_pkg::ADDR_RESULT) begin
        rdata_out <= result_ff;
      end else if (addr_in == adcsr_pkg::ADDR_CONV_CONTROL) begin
        rdata_out <= ctl_ff;
      end else if (addr_in == adcsr_pkg::ADDR_PIN_CONFIG) begin
        rdata_out <= {5'h00, pincfg_ff};
      end else if (addr_in == adcsr_pkg::ADDR_IRQ_MASK) begin
        rdata_out <= irq_mask_ff;
      end else begin
        rdata_out <= adcsr_pkg::RST_ZERO;
      end
    end else begin
      rdata_out <= adcsr_pkg::RST_ZERO;
    end
  end

  // ==========================================================
  // Front-end drive and interrupt level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dac_out <= adcsr_pkg::RST_ZERO;
      channel_out <= 2'h0;
      sample_out <= 1'b0;
    end else begin
      dac_out <= sar_ff;
      channel_out <= ctl_ff[adcsr_pkg::CTL_CHS_HI:adcsr_pkg::CTL_CHS_LO];
      sample_out <= (state_ff == ADCSR_IDLE) && powered_ff;
    end
  end

  assign powered_out = powered_ff;
  // Masked sticky flag, also gated by the core's enables
  assign irq_out = done_flag_ff && irq_mask_ff[adcsr_pkg::DONE_BIT]
                   && irqctl_ff[adcsr_pkg::PERIPH_IRQ_EN_BIT] && irqctl_ff[adcsr_pkg::GIE_BIT];
endmodule

// File: adcsr_ctrl_properties.sv
/*
  Port checker for the converter control block.
  Assumes it is bound onto adcsr_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
// ==========================================================
// Checker
module adcsr_ctrl_properties #(
  parameter int TAD_CYC = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Core and converter state
  input wire logic sleep_in,
  input wire logic wake_out,
  input wire logic [7:0] dac_out,
  input wire logic [1:0] channel_out,
  input wire logic powered_out,
  input wire logic irq_out
);
  logic [7:0] wq_ff;
  logic [1:0] clk_ff;
  logic mapped;
  // Last written data and clock field, so later reads can be judged
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wq_ff <= 8'h00;
      clk_ff <= 2'h0;
    end else if (wr_in) begin
      wq_ff <= wdata_in;
      if (addr_in == 8'h1F) begin
        clk_ff <= wdata_in[7:6];
      end
    end
  end
  // Decoded register locations
  assign mapped = addr_in inside {8'h0B, 8'h8B, 8'h0C, 8'h1E, 8'h1F, 8'h8C, 8'h9F, 8'h90};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_unmapped; rd_in && !mapped |=> rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_rsvd; rd_in && addr_in == 8'h1F |=> rdata_out[5] == 1'b0 && rdata_out[1] == 1'b0; endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits set");
  property p_flag_rsvd; rd_in && (addr_in == 8'h0C || addr_in == 8'h8C) |=> (rdata_out & 8'hBF) == 8'h00; endproperty
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag or enable spare bits set");
  property p_pin_rsvd; rd_in && addr_in == 8'h9F |=> rdata_out[7:3] == 5'h00; endproperty
  a_pin_rsvd: assert property (p_pin_rsvd) else $error("pin config spare bits set");
  property p_mirror; wr_in && addr_in == 8'h8B ##[1:2] rd_in && addr_in == 8'h0B |=> rdata_out[7:6] == wq_ff[7:6];
  endproperty
  a_mirror: assert property (p_mirror) else $error("bank mirror mismatch");
  property p_wake_sleep; wake_out |-> $past(sleep_in); endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
  property p_wake_pulse; wake_out |=> !wake_out; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  property p_reset; $past(rst_in) |-> !powered_out && !irq_out && dac_out == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_sleep_abort; $rose(sleep_in) && clk_ff != 2'h3 |-> ##[1:6] !powered_out; endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("converter kept power in sleep");
  property p_channel; wr_in && addr_in == 8'h1F |=> ##1 channel_out == wq_ff[4:3]; endproperty
  a_channel: assert property (p_channel) else $error("channel not taken from control");
endmodule
bind adcsr_ctrl adcsr_ctrl_properties #(.TAD_CYC(TAD_CYC)) i_adcsr_ctrl_properties (.clk_in(clk_in),
  .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .sleep_in(sleep_in), .wake_out(wake_out), .dac_out(dac_out),
  .channel_out(channel_out), .powered_out(powered_out), .irq_out(irq_out));

// File: adcsr_pkg.sv
/*
  Package for the converter sleep and reset control block: register
  addresses, field positions, reset values and timing counts.
  Assumes an 8-bit data-memory bus with bank-mirrored addresses.
*/
package adcsr_pkg;
  // ==========================================================
  // Register addresses (8-bit data memory space)
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_CONTROL_HI = 8'h8B;
  localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h1E;
  localparam logic [7:0] ADDR_CONV_CONTROL = 8'h1F;
  localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h8C;
  localparam logic [7:0] ADDR_PIN_CONFIG = 8'h9F;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h90;
  // ==========================================================
  // Field positions in the control register
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_GO_BIT = 2;
  localparam int CTL_CHS_LO = 3;
  localparam int CTL_CHS_HI = 4;
  localparam int CTL_CLK_LO = 6;
  localparam int CTL_CLK_HI = 7;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hDD;
  // Flag and enable registers share this bit
  localparam int DONE_BIT = 6;
  localparam logic [7:0] DONE_MASK = 8'h40;
  // Interrupt control: global and peripheral enables
  localparam int GIE_BIT = 7;
  localparam int PERIPH_IRQ_EN_BIT = 6;
  localparam logic [7:0] PIN_CFG_MASK = 8'h07;
  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h0;
  localparam int RES_BITS = 8;
  localparam int STEP_COUNT = 256;
  // ==========================================================
  // Timing: one instruction cycle is four clocks
  localparam int CLK_NS = 100;
  localparam int INSTR_NS = 400;
  localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAD_CYC_DEFAULT = 2;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage

// File: testbench.sv
/*
  Self-checking bench for the converter control block.
  Assumes the one-cycle register port and the analog source model.
*/
`timescale 1ns/100ps
// ==========================================================
// Bench
module testbench;
  logic clk_in, rst_in, por_in, wr_in, rd_in, sleep_in, comp_in, wake_out, powered_out, sample_out, irq_out;
  logic [7:0] addr_in, wdata_in, rdata_out, dac_out, level, d;
  logic [1:0] channel_out;
  int failures, n_compared, cyc, n_wake;
  logic [7:0] ra [8] = '{8'h1F, 8'h0C, 8'h8C, 8'h9F, 8'h0B, 8'h90, 8'h1E, 8'h55};
  logic [7:0] lv [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
  adcsr_ctrl i_adcsr_ctrl (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in),
    .wake_out(wake_out), .comp_in(comp_in), .dac_out(dac_out), .channel_out(channel_out),
    .powered_out(powered_out), .sample_out(sample_out), .irq_out(irq_out));
  adcsr_analog_model i_adcsr_analog_model (.dac_in(dac_out), .level_in(level), .comp_out(comp_in));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    chk(d, e);
  endtask
  // Polls the start bit; bounded so a stuck sequencer cannot hang
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      @(posedge clk_in);
      addr_in <= 8'h1F;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
      if (d[2] === 1'b0) break;
    end
    chk(d & 8'h04, 8'h00);
  endtask
  task automatic start(input logic [7:0] ctl, input logic [7:0] lvl, input logic slp);
    level <= lvl;
    wr(8'h1F, ctl);
    rdc(8'h1F, ctl);
    sleep_in <= slp;
  endtask
  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cycle ceiling and wake pulse count
  always @(posedge clk_in) begin
    cyc++;
    if (wake_out === 1'b1) n_wake++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {rst_in, por_in, wr_in, rd_in, sleep_in, addr_in, wdata_in, level} = {2'b11, 3'b000, 24'h0};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    foreach (ra[i]) rdc(ra[i], 8'h00);
    wr(8'h9F, 8'hFF);
    rdc(8'h9F, 8'h07);
    wr(8'h1F, 8'hFA);
    rdc(8'h1F, 8'hD8);
    wr(8'h8B, 8'hC0);
    rdc(8'h0B, 8'hC0);
    wr(8'h90, 8'h40);
    // Awake conversions across the code range, interrupt raised and cleared
    foreach (lv[i]) begin
      start(8'h1D, lv[i], 1'b0);
      wait_idle();
      rdc(8'h1E, lv[i]);
      rdc(8'h0C, 8'h40);
      chk({7'h00, irq_out}, 8'h01);
      wr(8'h90, 8'h00);
      #1 chk({7'h00, irq_out}, 8'h00);
      wr(8'h90, 8'h40);
      wr(8'h0C, 8'h40);
      #1 chk({7'h00, irq_out}, 8'h00);
    end
    chk({6'h00, channel_out}, 8'h03);
    chk({7'h00, sample_out}, 8'h01);
    // RC clock in sleep with its interrupt enabled wakes the core
    wr(8'h8C, 8'h40);
    start(8'hC5, 8'h5A, 1'b1);
    for (int k = 0; k < 300 && n_wake == 0; k++) @(posedge clk_in);
    sleep_in <= 1'b0;
    chk(n_wake[7:0], 8'h01);
    rdc(8'h1E, 8'h5A);
    wr(8'h0C, 8'h40);
    wr(8'h8C, 8'h00);
    // RC clock in sleep without interrupt powers down, on bit kept
    start(8'hC5, 8'hA5, 1'b1);
    wait_idle();
    repeat (3) @(posedge clk_in);
    chk({7'h00, powered_out}, 8'h00);
    rdc(8'h1F, 8'hC1);
    rdc(8'h1E, 8'hA5);
    chk(n_wake[7:0], 8'h01);
    sleep_in <= 1'b0;
    wr(8'h0C, 8'h40);
    // Other clock: sleep aborts the conversion
    start(8'h05, 8'h33, 1'b1);
    repeat (8) @(posedge clk_in);
    chk({7'h00, powered_out}, 8'h00);
    rdc(8'h1F, 8'h01);
    rdc(8'h0C, 8'h00);
    rdc(8'h1E, 8'hA5);
    sleep_in <= 1'b0;
    // Reset mid-conversion keeps the result; power-on clears it
    start(8'h05, 8'h33, 1'b0);
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(8'h1F, 8'h00);
    chk({7'h00, powered_out}, 8'h00);
    rdc(8'h1E, 8'hA5);
    por_in <= 1'b1;
    @(posedge clk_in);
    por_in <= 1'b0;
    rdc(8'h1E, 8'h00);
    give_verdict();
  end
endmodule
